// ===== logic/urxb_top.sv
`timescale 1ns/10ps
`include "urxb_map.svh"
module urxb_top
    import urxb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rxPin,
    input wire logic sampleTick,
    input wire logic globalIrqEn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic rxIrq,
    output logic rxPinOverride
);

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [3:0] charBits(input logic [2:0] size);
        if (size == `URXB_SIZE_NINE) begin
            charBits = 4'h9;
        end else if (size[2]) begin
            charBits = 4'h8;
        end else begin
            charBits = 4'h5 + {2'h0, size[1:0]};
        end
    endfunction

    logic rxMeta_q, rxSync_q;
    urxb_cfg_t cfg_q, cfg_d;
    logic [7:0] rdData_q, rdData_d;
    urxb_state_t state_q, state_d;
    logic [4:0] smpCnt_q, smpCnt_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [8:0] shift_q, shift_d;
    logic [1:0] votes_q, votes_d;
    logic parBit_q, parBit_d;
    logic rxPrev_q, rxPrev_d;
    logic waitValid_q, waitValid_d;
    urxb_entry_t waitEntry_q, waitEntry_d;
    logic ovrPend_q, ovrPend_d;
    logic [4:0] ovs, vFirst, curSmp;
    logic inVote, lastVote, bitVal;
    logic stopDone, startValid, startReject;
    logic [3:0] nBits;
    logic [8:0] aligned;
    urxb_entry_t newEntry, fifoIn, headEntry;
    logic fifoPush, fifoPop, fifoNotEmpty, fifoFull;
    logic [1:0] fifoCount;

    // Line synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
        end else begin
            rxMeta_q <= rxPin;
            rxSync_q <= rxMeta_q;
        end
    end

    assign ovs = cfg_q.dblSpeed ? `URXB_OVS_DOUBLE : `URXB_OVS_NORMAL;
    assign vFirst = cfg_q.dblSpeed ? `URXB_VOTE_DOUBLE : `URXB_VOTE_NORMAL;
    assign curSmp = (smpCnt_q == ovs) ? 5'h01 : smpCnt_q + 5'h01;
    assign inVote = (curSmp >= vFirst) && (curSmp <= vFirst + 5'h02);
    assign lastVote = (curSmp == vFirst + 5'h02);
    assign bitVal = maj3(votes_q[1], votes_q[0], rxSync_q);
    assign nBits = charBits(cfg_q.size);

    always_comb begin
        state_d = state_q;
        smpCnt_d = smpCnt_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        votes_d = votes_q;
        parBit_d = parBit_q;
        rxPrev_d = rxPrev_q;
        stopDone = 1'b0;
        startValid = 1'b0;
        startReject = 1'b0;
        if (sampleTick) begin
            rxPrev_d = rxSync_q;
            smpCnt_d = curSmp;
            if (inVote && !lastVote) begin
                votes_d = {votes_q[0], rxSync_q};
            end
            unique case (state_q)
                URXB_IDLE: begin
                    if (rxPrev_q && !rxSync_q) begin
                        state_d = URXB_START;
                        smpCnt_d = 5'h01;
                    end
                end
                URXB_START: begin
                    if (lastVote) begin
                        if (bitVal) begin
                            state_d = URXB_IDLE;
                            startReject = 1'b1;
                        end else begin
                            startValid = 1'b1;
                            bitCnt_d = 4'h0;
                            state_d = URXB_DATA;
                        end
                    end
                end
                URXB_DATA: begin
                    if (lastVote) begin
                        shift_d = {bitVal, shift_q[8:1]};
                        bitCnt_d = bitCnt_q + 4'h1;
                        if (bitCnt_q == nBits - 4'h1) begin
                            state_d = cfg_q.parEn ? URXB_PARITY : URXB_STOP;
                        end
                    end
                end
                URXB_PARITY: begin
                    if (lastVote) begin
                        parBit_d = bitVal;
                        state_d = URXB_STOP;
                    end
                end
                URXB_STOP: begin
                    if (lastVote) begin
                        stopDone = 1'b1;
                        state_d = URXB_IDLE;
                    end
                end
            endcase
        end
        if (!cfg_q.receiver_enable) begin
            state_d = URXB_IDLE;
            stopDone = 1'b0;
            startValid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= URXB_IDLE;
            smpCnt_q <= 5'h00;
            bitCnt_q <= 4'h0;
            shift_q <= 9'h000;
            votes_q <= 2'h0;
            parBit_q <= 1'b0;
            rxPrev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            smpCnt_q <= smpCnt_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            votes_q <= votes_d;
            parBit_q <= parBit_d;
            rxPrev_q <= rxPrev_d;
        end
    end

    assign aligned = shift_q >> (4'h9 - nBits);

    always_comb begin
        newEntry.data = aligned;
        newEntry.frameErr = ~bitVal;
        newEntry.overrun = 1'b0;
        newEntry.parityErr = cfg_q.parEn & (parBit_q ^ (^aligned) ^ cfg_q.parOdd);
    end

    always_comb begin
        waitValid_d = waitValid_q;
        waitEntry_d = waitEntry_q;
        ovrPend_d = ovrPend_q;
        fifoPush = 1'b0;
        fifoIn = waitEntry_q;
        if (waitValid_q && !fifoFull) begin
            fifoPush = 1'b1;
            waitValid_d = 1'b0;
        end
        if (stopDone) begin
            if (!fifoPush && !fifoFull) begin
                fifoPush = 1'b1;
                fifoIn = newEntry;
            end else begin
                waitValid_d = 1'b1;
                waitEntry_d = newEntry;
            end
        end
        fifoIn.overrun = ovrPend_q;
        if (fifoPush) begin
            ovrPend_d = 1'b0;
        end
        if (startValid && waitValid_q && fifoFull) begin
            waitValid_d = 1'b0;
            ovrPend_d = 1'b1;
        end
        if (!cfg_q.receiver_enable) begin
            waitValid_d = 1'b0;
            ovrPend_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waitValid_q <= 1'b0;
            waitEntry_q <= '0;
            ovrPend_q <= 1'b0;
        end else begin
            waitValid_q <= waitValid_d;
            waitEntry_q <= waitEntry_d;
            ovrPend_q <= ovrPend_d;
        end
    end

    urxb_fifo u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .flush(~cfg_q.receiver_enable),
        .push(fifoPush),
        .pushEntry(fifoIn),
        .pop(fifoPop),
        .headEntry(headEntry),
        .notEmpty(fifoNotEmpty),
        .full(fifoFull),
        .count(fifoCount)
    );

    always_comb begin
        cfg_d = cfg_q;
        rdData_d = 8'h00;
        fifoPop = 1'b0;
        if (regWr) begin
            unique case (regAddr)
                `URXB_ADDR_CSA: cfg_d.dblSpeed = regWdata[`URXB_CSA_DOUBLE_SPEED];
                `URXB_ADDR_CSB: begin
                    cfg_d.irqEn = regWdata[`URXB_CSB_IRQ_EN];
                    cfg_d.receiver_enable = regWdata[`URXB_CSB_RX_EN];
                    cfg_d.size[2] = regWdata[`URXB_CSB_SIZE_HI];
                    cfg_d.ninthTx = regWdata[`URXB_CSB_NINTH_TX];
                end
                `URXB_ADDR_CSC: begin
                    cfg_d.parEn = regWdata[`URXB_CSC_PAR_EN];
                    cfg_d.parOdd = regWdata[`URXB_CSC_PAR_ODD];
                    cfg_d.stop2 = regWdata[`URXB_CSC_STOP2];
                    cfg_d.size[1:0] = regWdata[`URXB_CSC_SIZE_LO +: 2];
                end
                default: begin
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                `URXB_ADDR_CSA: begin
                    rdData_d[`URXB_CSA_COMPLETE] = fifoNotEmpty;
                    rdData_d[`URXB_CSA_FRAME_ERR] = fifoNotEmpty & headEntry.frameErr;
                    rdData_d[`URXB_CSA_OVERRUN] = fifoNotEmpty & headEntry.overrun;
                    rdData_d[`URXB_CSA_PARITY_ERR] = fifoNotEmpty & headEntry.parityErr;
                    rdData_d[`URXB_CSA_DOUBLE_SPEED] = cfg_q.dblSpeed;
                end
                `URXB_ADDR_CSB: begin
                    rdData_d[`URXB_CSB_IRQ_EN] = cfg_q.irqEn;
                    rdData_d[`URXB_CSB_RX_EN] = cfg_q.receiver_enable;
                    rdData_d[`URXB_CSB_SIZE_HI] = cfg_q.size[2];
                    rdData_d[`URXB_CSB_NINTH_RX] = fifoNotEmpty & headEntry.data[8];
                    rdData_d[`URXB_CSB_NINTH_TX] = cfg_q.ninthTx;
                end
                `URXB_ADDR_CSC: begin
                    rdData_d[`URXB_CSC_PAR_EN] = cfg_q.parEn;
                    rdData_d[`URXB_CSC_PAR_ODD] = cfg_q.parOdd;
                    rdData_d[`URXB_CSC_STOP2] = cfg_q.stop2;
                    rdData_d[`URXB_CSC_SIZE_LO +: 2] = cfg_q.size[1:0];
                end
                `URXB_ADDR_DATA: begin
                    rdData_d = fifoNotEmpty ? headEntry.data[7:0] : 8'h00;
                    fifoPop = fifoNotEmpty;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= `URXB_CFG_RESET;
            rdData_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdata = rdData_q;
    assign rxPinOverride = cfg_q.receiver_enable;
    assign rxIrq = globalIrqEn & cfg_q.irqEn & fifoNotEmpty;

    property p_rxc_read;
        @(posedge core_clk) disable iff (rst)
        regRd && regAddr == `URXB_ADDR_CSA |=> regRdata[`URXB_CSA_COMPLETE] == $past(fifoNotEmpty);
    endproperty
    a_rxc_read: assert property (p_rxc_read) else $error("complete flag read mismatch");

    property p_flush;
        @(posedge core_clk) disable iff (rst)
        !cfg_q.receiver_enable |=> !fifoNotEmpty && !waitValid_q && state_q == URXB_IDLE;
    endproperty
    a_flush: assert property (p_flush) else $error("disable did not flush");

    property p_irq_level;
        @(posedge core_clk) disable iff (rst)
        globalIrqEn && cfg_q.irqEn && fifoNotEmpty && !fifoPop && !regWr |=> rxIrq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt dropped early");

    property p_no_err_irq;
        @(posedge core_clk) disable iff (rst)
        !fifoNotEmpty |-> !rxIrq;
    endproperty
    a_no_err_irq: assert property (p_no_err_irq) else $error("interrupt without data");

    property p_csa_write;
        @(posedge core_clk) disable iff (rst)
        regWr && regAddr == `URXB_ADDR_CSA && !fifoPush && !fifoPop && cfg_q.receiver_enable |=> $stable(headEntry);
    endproperty
    a_csa_write: assert property (p_csa_write) else $error("flags changed by write");

    property p_pop_advance;
        @(posedge core_clk) disable iff (rst)
        fifoPop && !fifoPush && cfg_q.receiver_enable |=> fifoCount == $past(fifoCount) - 2'h1;
    endproperty
    a_pop_advance: assert property (p_pop_advance) else $error("read did not advance");

    property p_overrun;
        @(posedge core_clk) disable iff (rst)
        startValid && waitValid_q && fifoFull |=> ovrPend_q && !waitValid_q;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_ovr_clear;
        @(posedge core_clk) disable iff (rst)
        fifoPush && !(startValid && waitValid_q && fifoFull) |=> !ovrPend_q;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

    property p_parity_off;
        @(posedge core_clk) disable iff (rst)
        stopDone && !cfg_q.parEn |-> !newEntry.parityErr;
    endproperty
    a_parity_off: assert property (p_parity_off) else $error("parity error while disabled");

    property p_start_detect;
        @(posedge core_clk) disable iff (rst)
        cfg_q.receiver_enable && state_q == URXB_IDLE && sampleTick && rxPrev_q && !rxSync_q
            |=> state_q == URXB_START && smpCnt_q == 5'h01;
    endproperty
    a_start_detect: assert property (p_start_detect) else $error("start edge missed");

    property p_reject;
        @(posedge core_clk) disable iff (rst)
        startReject |=> state_q == URXB_IDLE;
    endproperty
    a_reject: assert property (p_reject) else $error("noise start not rejected");

    property p_wrap;
        @(posedge core_clk) disable iff (rst)
        sampleTick && cfg_q.receiver_enable && state_q != URXB_IDLE && smpCnt_q == ovs |=> smpCnt_q == 5'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("sample count wrap wrong");

    property p_short_char;
        @(posedge core_clk) disable iff (rst)
        stopDone && cfg_q.size == 3'h0 |-> newEntry.data[8:5] == 4'h0;
    endproperty
    a_short_char: assert property (p_short_char) else $error("upper bits not zero");

    c_overrun: cover property (@(posedge core_clk) disable iff (rst) startValid && waitValid_q && fifoFull);
    c_frame_err: cover property (@(posedge core_clk) disable iff (rst) fifoPush && fifoIn.frameErr);
    c_reject: cover property (@(posedge core_clk) disable iff (rst) startReject);
    c_double: cover property (@(posedge core_clk) disable iff (rst) stopDone && cfg_q.dblSpeed);

endmodule

// ===== logic/urxb_map.svh
`ifndef URXB_MAP_SVH
`define URXB_MAP_SVH

// Register byte addresses
`define URXB_ADDR_CSA 4'h0
`define URXB_ADDR_CSB 4'h4
`define URXB_ADDR_CSC 4'h8
`define URXB_ADDR_DATA 4'hC

// control_status_a fields
`define URXB_CSA_COMPLETE 7
`define URXB_CSA_FRAME_ERR 4
`define URXB_CSA_OVERRUN 3
`define URXB_CSA_PARITY_ERR 2
`define URXB_CSA_DOUBLE_SPEED 1

// control_status_b fields
`define URXB_CSB_IRQ_EN 7
`define URXB_CSB_RX_EN 4
`define URXB_CSB_SIZE_HI 2
`define URXB_CSB_NINTH_RX 1
`define URXB_CSB_NINTH_TX 0

// control_status_c fields
`define URXB_CSC_PAR_EN 5
`define URXB_CSC_PAR_ODD 4
`define URXB_CSC_STOP2 3
`define URXB_CSC_SIZE_LO 1

// Reset values
`define URXB_CFG_RESET 10'h000

// Character size codes and oversampling timing
`define URXB_SIZE_NINE 3'h7
`define URXB_OVS_NORMAL 5'h10
`define URXB_OVS_DOUBLE 5'h08
`define URXB_VOTE_NORMAL 5'h08
`define URXB_VOTE_DOUBLE 5'h04

`endif

// ===== logic/urxb_pkg.sv
package urxb_pkg;

    typedef struct packed {
        logic [8:0] data;
        logic frameErr;
        logic overrun;
        logic parityErr;
    } urxb_entry_t;

    typedef struct packed {
        logic receiver_enable;
        logic irqEn;
        logic dblSpeed;
        logic parEn;
        logic parOdd;
        logic stop2;
        logic [2:0] size;
        logic ninthTx;
    } urxb_cfg_t;

    typedef enum logic [2:0] {
        URXB_IDLE,
        URXB_START,
        URXB_DATA,
        URXB_PARITY,
        URXB_STOP
    } urxb_state_t;

endpackage

// ===== logic/urxb_fifo.sv
`timescale 1ns/10ps
module urxb_fifo
    import urxb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push,
    input wire urxb_entry_t pushEntry,
    input wire logic pop,
    output urxb_entry_t headEntry,
    output logic notEmpty,
    output logic full,
    output logic [1:0] count
);

    urxb_entry_t mem_q [2];
    urxb_entry_t mem_d [2];
    logic wrPtr_q, wrPtr_d;
    logic rdPtr_q, rdPtr_d;
    logic [1:0] cnt_q, cnt_d;

    always_comb begin
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        cnt_d = cnt_q;
        if (flush) begin
            wrPtr_d = 1'b0;
            rdPtr_d = 1'b0;
            cnt_d = 2'h0;
        end else begin
            if (push && cnt_q != 2'h2) begin
                mem_d[wrPtr_q] = pushEntry;
                wrPtr_d = ~wrPtr_q;
            end
            if (pop && cnt_q != 2'h0) begin
                rdPtr_d = ~rdPtr_q;
            end
            cnt_d = cnt_q + 2'((push && cnt_q != 2'h2) ? 1 : 0) - 2'((pop && cnt_q != 2'h0) ? 1 : 0);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            cnt_q <= cnt_d;
        end
    end

    assign headEntry = mem_q[rdPtr_q];
    assign notEmpty = (cnt_q != 2'h0);
    assign full = (cnt_q == 2'h2);
    assign count = cnt_q;

endmodule

// ===== tb/urxb_tx_model.sv
`timescale 1ns/10ps
module urxb_tx_model (
    input wire logic core_clk,
    input wire logic sampleTick,
    output logic rxLine
);
    int ovs = 16;
    initial rxLine = 1'b1;
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            while (sampleTick !== 1'b1) @(posedge core_clk);
        end
    endtask
    // Frame bits LSB first; bit g gets its centre sample flipped
    task automatic send(input logic [11:0] b, input int n, input int g);
        for (int i = 0; i < n; i++) begin
            rxLine <= b[i];
            if (i == g) begin
                ticks(ovs / 2);
                rxLine <= ~b[i];
                ticks(1);
                rxLine <= b[i];
                ticks(ovs / 2 - 1);
            end else begin
                ticks(ovs);
            end
        end
        rxLine <= 1'b1;
        ticks(ovs);
    endtask
    task automatic spike(input int n);
        rxLine <= 1'b0;
        ticks(n);
        rxLine <= 1'b1;
        ticks(2 * ovs);
    endtask
endmodule

// ===== tb/urxb_top_test.sv
`timescale 1ns/10ps
`include "urxb_map.svh"
module urxb_top_test;
    import urxb_pkg::*;
    logic core_clk, rst, sampleTick, globalIrqEn, regWr, regRd, rxPin, rxIrq, rxPinOverride;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [1:0] tc = 2'h0;
    logic [11:0] fb;
    logic irqEn, dbl, odd, parOn;
    int err_count, samples_checked, len;

    urxb_top uut (.core_clk(core_clk), .rst(rst), .rxPin(rxPin), .sampleTick(sampleTick),
        .globalIrqEn(globalIrqEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .rxIrq(rxIrq), .rxPinOverride(rxPinOverride));
    urxb_tx_model mdl (.core_clk(core_clk), .sampleTick(sampleTick), .rxLine(rxPin));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        tc <= tc + 2'h1;
        sampleTick <= (tc == 2'h3);
    end

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk(regRdata, e);
        @(posedge core_clk);
    endtask
    task automatic cfg(input int n, input logic [2:0] pm, input logic ie, input logic ds);
        logic [2:0] sz;
        sz = (n == 9) ? 3'h7 : 3'(n - 5);
        dbl = ds;
        irqEn = ie;
        parOn = pm[2];
        odd = pm[1];
        mdl.ovs = ds ? 8 : 16;
        wr(`URXB_ADDR_CSC, {2'h0, pm, sz[1:0], 1'b0});
        wr(`URXB_ADDR_CSB, {ie, 2'h0, 1'b1, 1'b0, sz[2], 2'h0});
        wr(`URXB_ADDR_CSA, {6'h0, ds, 1'b0});
        chk({7'h0, rxPinOverride}, 8'h01);
        rdc(`URXB_ADDR_CSC, {2'h0, pm, sz[1:0], 1'b0});
    endtask
    function automatic logic [11:0] mk(input logic [8:0] d, input int n, input int par, input logic st);
        logic [11:0] b;
        b = '0;
        for (int i = 0; i < n; i++) b[i + 1] = d[i];
        len = n + 1;
        if (par != 0) begin
            b[len] = ^(d & 9'((1 << n) - 1)) ^ odd ^ (par == 2);
            len++;
        end
        b[len] = st;
        len++;
        return b;
    endfunction
    task automatic rdFrame(input logic [8:0] d, input int n, input int par, input logic st, input logic overrun_flag);
        logic [8:0] m;
        m = d & 9'((1 << n) - 1);
        chk({7'h0, rxIrq}, {7'h0, globalIrqEn & irqEn});
        rdc(`URXB_ADDR_CSA, {1'b1, 2'h0, ~st, overrun_flag, par == 2, dbl, 1'b0});
        rdc(`URXB_ADDR_CSB, {irqEn, 2'h0, 1'b1, 1'b0, n == 9, m[8], 1'b0});
        rdc(`URXB_ADDR_DATA, m[7:0]);
    endtask
    task automatic rxOne(input logic [8:0] d, input int n, input logic st, input int g);
        int par;
        par = parOn ? int'($urandom_range(1, 2)) : 0;
        fb = mk(d, n, par, st);
        mdl.send(fb, len, g);
        rdFrame(d, n, par, st, 1'b0);
        chk({7'h0, rxIrq}, 8'h00);
    endtask

    initial begin
        {globalIrqEn, regWr, regRd, regAddr, regWdata} = '0;
        rst = 1'b1;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'h599d0249));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdc(`URXB_ADDR_CSA, 8'h00);
        rdc(`URXB_ADDR_CSB, 8'h00);
        rdc(`URXB_ADDR_CSC, 8'h00);
        $display("test reset done");
        // Random frames over every size and speed, with a random parity mode
        for (int s = 0; s < 2; s++) begin
            for (int n = 5; n <= 9; n++) begin
                cfg(n, 3'($urandom), 1'($urandom), s[0]);
                repeat (3) begin
                    globalIrqEn <= 1'($urandom);
                    rxOne(9'($urandom), n, $urandom_range(0, 3) != 0, $urandom_range(0, 12));
                end
            end
        end
        $display("test random done");
        for (int s = 0; s < 2; s++) begin
            cfg(8, 3'h0, 1'b0, s[0]);
            mdl.spike(s ? 4 : 8);
            rdc(`URXB_ADDR_CSA, {6'h0, s[0], 1'b0});
            rxOne(9'h0A5, 8, 1'b1, 99);
        end
        $display("test spike done");
        cfg(8, 3'h0, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            fb = mk(9'(8'h30 + i), 8, 0, 1'b1);
            mdl.send(fb, len, 99);
        end
        wr(`URXB_ADDR_CSA, 8'h1C);
        rdFrame(9'h30, 8, 0, 1'b1, 1'b0);
        rdFrame(9'h31, 8, 0, 1'b1, 1'b0);
        rdFrame(9'h33, 8, 0, 1'b1, 1'b1);
        rdc(`URXB_ADDR_CSA, 8'h00);
        rxOne(9'h05A, 8, 1'b1, 99);
        $display("test overrun done");
        fb = mk(9'h03C, 8, 0, 1'b1);
        mdl.send(fb, len, 99);
        mdl.send(fb, len, 99);
        wr(`URXB_ADDR_CSB, 8'h00);
        rdc(`URXB_ADDR_CSA, 8'h00);
        chk({7'h0, rxPinOverride}, 8'h00);
        cfg(8, 3'h0, 1'b0, 1'b0);
        fork
            mdl.send(fb, len, 99);
            begin
                repeat (300) @(posedge core_clk);
                wr(`URXB_ADDR_CSB, 8'h00);
            end
        join
        cfg(8, 3'h0, 1'b0, 1'b0);
        rdc(`URXB_ADDR_CSA, 8'h00);
        $display("test disable done");
        results;
    end

    // About three times the expected run length
    initial begin
        #300000;
        err_count++;
        results;
    end
endmodule
